/* verilog/cc_clock_ctrl.sv */
// Clock source, PLL, divider, gating and sleep control with APB registers
`timescale 1ns/1ps
`include "cc_defs.svh"
module cc_clock_ctrl
	import cc_pkg::*;
#(
	parameter int LOCK_CYCLES = `CC_PLL_SETTLE_US * `CC_CLK_MHZ
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Oscillator levels
	input wire logic internal_rc_oscillator,
	input wire logic sys_oscillator,
	input wire logic watchdog_oscillator,
	input wire logic rtc_osc_32k,
	// Wake request from peripheral interrupt logic
	input wire logic wake_irq,
	// Generated clocks
	output logic main_clk,
	output logic core_clk,
	output logic usb_clk,
	output logic watchdog_timer_clock,
	output logic clock_output_pin,
	output logic rtc_clk_1hz,
	output logic rtc_clk_1khz,
	output logic [`CC_NPER-1:0] periph_clk,
	output logic [1:0] periph_div_clk,
	// Status
	output logic core_sleeping
);
	localparam logic [15:0] LOCK_N = 16'(LOCK_CYCLES);

	// Register state
	logic [2:0] main_sel;
	logic [1:0] clock_output_pin_sel;
	logic wdt_sel;
	logic [`CC_DIV_W-1:0] div_n [3];
	logic [`CC_NPER-1:0] gate;
	cc_pll_cfg_s pll_cfg [2];
	logic [1:0] pll_lock;
	logic [1:0] pll_out;
	logic [2:0] main_cur;
	cc_status_s status;

	// Oscillator input synchronisers
	logic [3:0] osc_s1;
	logic [3:0] osc_s2;
	logic [3:0] osc_s3;
	logic [3:0] osc_f;
	wire [3:0] osc_in = {rtc_osc_32k, watchdog_oscillator,
		sys_oscillator, internal_rc_oscillator};
	wire [3:0] osc_agree = ~(osc_s2 ^ osc_s3);
	wire [3:0] next_osc_f = (osc_agree & osc_s3) | (~osc_agree & osc_f);
	wire irc_f = osc_f[0];
	wire sys_f = osc_f[1];
	wire wdo_f = osc_f[2];
	wire rtc_f = osc_f[3];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_s1 <= '0;
			osc_s2 <= '0;
			osc_s3 <= '0;
			osc_f <= '0;
		end else begin
			osc_s1 <= osc_in;
			osc_s2 <= osc_s1;
			osc_s3 <= osc_s2;
			osc_f <= next_osc_f;
		end
	end

	// APB decode
	wire acc = psel && penable;
	wire xfer = acc && pready;
	wire wr = xfer && pwrite;
	wire hit_main = paddr == `CC_OFF_MAINSEL;
	wire hit_spll = paddr == `CC_OFF_SYSPLL;
	wire hit_upll = paddr == `CC_OFF_USBPLL;
	wire hit_stat = paddr == `CC_OFF_STATUS;
	wire hit_cout = paddr == `CC_OFF_CLOCK_OUTPUT_PIN;
	wire hit_wdt = paddr == `CC_OFF_WDTSEL;
	wire hit_cdiv = paddr == `CC_OFF_CPUDIV;
	wire hit_gate = paddr == `CC_OFF_GATE;
	wire hit_pd0 = paddr == `CC_OFF_PDIV0;
	wire hit_pd1 = paddr == `CC_OFF_PDIV1;
	wire hit_slp = paddr == `CC_OFF_SLEEP;
	wire hit = hit_main | hit_spll | hit_upll | hit_stat | hit_cout |
		hit_wdt | hit_cdiv | hit_gate | hit_pd0 | hit_pd1 | hit_slp;
	wire [1:0] wr_pll = {wr && hit_upll, wr && hit_spll};
	wire [2:0] wr_div = {wr && hit_pd1, wr && hit_pd0, wr && hit_cdiv};
	wire [31:0] rd_data =
		hit_main ? {29'h0, main_sel} :
		hit_spll ? {21'h0, pll_cfg[0]} :
		hit_upll ? {21'h0, pll_cfg[1]} :
		hit_stat ? {26'h0, status} :
		hit_cout ? {30'h0, clock_output_pin_sel} :
		hit_wdt ? {31'h0, wdt_sel} :
		hit_cdiv ? {24'h0, div_n[0]} :
		hit_gate ? {24'h0, gate} :
		hit_pd0 ? {24'h0, div_n[1]} :
		hit_pd1 ? {24'h0, div_n[2]} :
		hit_slp ? {31'h0, core_sleeping} : 32'h0000_0000;

	assign status = '{main_src: main_cur, sleeping: core_sleeping,
		lock: pll_lock};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= acc && !pready;
			pslverr <= acc && !pready && !hit;
			if (acc && !pready)
				prdata <= pwrite ? 32'h0000_0000 : rd_data;
		end
	end

	// Selection and gate registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			main_sel <= CC_SRC_IRC; // [RL1]
			clock_output_pin_sel <= 2'b00;
			wdt_sel <= 1'b0;
			gate <= `CC_RST_GATE;
		end else if (wr) begin
			if (hit_main)
				main_sel <= pwdata[2:0]; // [RL13] [RL14]
			if (hit_cout)
				clock_output_pin_sel <= pwdata[1:0]; // [RL10]
			if (hit_wdt)
				wdt_sel <= pwdata[0]; // [RL15]
			if (hit_gate)
				gate <= pwdata[`CC_NPER-1:0]; // [RL17]
		end
	end

	// Sleep control: a wake request beats a sleep write in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			core_sleeping <= 1'b0;
		else if (wake_irq)
			core_sleeping <= 1'b0; // [RL20]
		else if (wr && hit_slp && pwdata[0])
			core_sleeping <= 1'b1; // [RL19]
	end

	// System and USB PLLs, identical
	logic [15:0] lock_cnt [2];
	logic [7:0] credit [2];
	genvar g;
	generate
	for (g = 0; g < 2; g++) begin : gen_pll // [RL9]
		cc_pll_cfg_s cfg_q;
		logic in_q;
		wire pin = pll_cfg[g].src ? sys_f : irc_f;
		wire in_rise = pin && !in_q;
		wire [6:0] mult2 = {1'b0, pll_cfg[g].msel, 1'b0} + 7'd2; // [RL2]
		wire [7:0] ratio = 8'd2 << pll_cfg[g].psel; // [RL3]
		wire tog = credit[g] >= ratio;
		wire [8:0] sum = {1'b0, credit[g]} - {1'b0, tog ? ratio : 8'h00} +
			(in_rise ? {2'b00, mult2} : 9'h000);
		wire [7:0] next_credit = sum[8] ? 8'hFF : sum[7:0];
		wire restart = !pll_cfg[g].en || pll_cfg[g] != cfg_q;

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn)
				pll_cfg[g] <= `CC_RST_PLL; // [RL6]
			else if (wr_pll[g])
				pll_cfg[g] <= pwdata[`CC_PLL_W-1:0];
		end

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				cfg_q <= `CC_RST_PLL;
				lock_cnt[g] <= 16'h0000;
				pll_lock[g] <= 1'b0;
			end else begin
				cfg_q <= pll_cfg[g];
				if (restart) begin
					lock_cnt[g] <= 16'h0000;
					pll_lock[g] <= 1'b0;
				end else if (lock_cnt[g] == LOCK_N)
					pll_lock[g] <= 1'b1; // [RL8]
				else
					lock_cnt[g] <= lock_cnt[g] + 16'h0001;
			end
		end

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				in_q <= 1'b0;
				credit[g] <= 8'h00;
				pll_out[g] <= 1'b0;
			end else begin
				in_q <= pin;
				if (pll_cfg[g].bypass) begin
					credit[g] <= 8'h00;
					pll_out[g] <= pin; // [RL6]
				end else if (!pll_lock[g]) begin
					credit[g] <= 8'h00;
					pll_out[g] <= 1'b0;
				end else begin
					credit[g] <= next_credit; // [RL2]
					pll_out[g] <= pll_out[g] ^ tog; // [RL3]
				end
			end
		end

		AST_LOCK_SETTLED: // [RL8]
		assert property (@(posedge pclk) disable iff (!presetn)
			$rose(pll_lock[g]) |-> lock_cnt[g] == LOCK_N && $past(!restart))
		else $error("pll lock without full settling count");

		AST_PLL_HALF_PERIOD: // [RL3]
		assert property (@(posedge pclk) disable iff (!presetn)
			pll_lock[g] && !pll_cfg[g].bypass && $changed(pll_out[g]) &&
			$past(pll_lock[g] && !pll_cfg[g].bypass)
			|-> $past(credit[g]) >= $past(ratio))
		else $error("pll output toggled early");
	end
	endgenerate

	assign usb_clk = pll_out[1];

	// Source selectors
	cc_glitchless_mux #(.N(8), .W(3)) u_main_mux (
		.pclk(pclk),
		.presetn(presetn),
		.src({3'b000, rtc_f, pll_out[0], wdo_f, sys_f, irc_f}), // [RL16]
		.sel(main_sel),
		.out(main_clk),
		.cur(main_cur)
	);
	cc_glitchless_mux #(.N(2), .W(1)) u_wdt_mux (
		.pclk(pclk),
		.presetn(presetn),
		.src({wdo_f, irc_f}),
		.sel(wdt_sel),
		.out(watchdog_timer_clock),
		.cur()
	);
	cc_glitchless_mux #(.N(4), .W(2)) u_cout_mux (
		.pclk(pclk),
		.presetn(presetn),
		.src({main_clk, wdo_f, sys_f, irc_f}),
		.sel(clock_output_pin_sel),
		.out(clock_output_pin),
		.cur()
	);

	// CPU divider and two peripheral dividers on the main clock
	logic main_q;
	logic [`CC_DIV_W-1:0] div_cnt [3];
	logic [2:0] div_lvl;
	wire main_rise = main_clk && !main_q;
	genvar d;
	generate
	for (d = 0; d < 3; d++) begin : gen_div // [RL18]
		wire last = div_cnt[d] == div_n[d] - 8'h01;
		wire [7:0] next_cnt = last ? 8'h00 : div_cnt[d] + 8'h01;
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn)
				div_n[d] <= d == 0 ? `CC_RST_CPUDIV : `CC_RST_PDIV;
			else if (wr_div[d])
				div_n[d] <= pwdata[`CC_DIV_W-1:0];
		end
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				div_cnt[d] <= 8'h00;
				div_lvl[d] <= 1'b0;
			end else if (div_n[d] == 8'h00) begin
				div_cnt[d] <= 8'h00;
				div_lvl[d] <= 1'b0;
			end else if (div_n[d] == 8'h01)
				div_lvl[d] <= main_clk;
			else if (main_rise) begin
				div_cnt[d] <= next_cnt;
				div_lvl[d] <= next_cnt < (div_n[d] >> 1);
			end
		end
	end
	endgenerate

	// Core and peripheral clock gates, switched only while clock is low
	logic core_run;
	logic [`CC_NPER-1:0] periph_run;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			main_q <= 1'b0;
			core_run <= 1'b1;
			core_clk <= 1'b0;
			periph_run <= '0;
			periph_clk <= '0;
			periph_div_clk <= 2'b00;
		end else begin
			main_q <= main_clk;
			if (!div_lvl[0])
				core_run <= !core_sleeping; // [RL19]
			core_clk <= div_lvl[0] && core_run; // [RL18]
			if (!main_clk)
				periph_run <= gate; // [RL17]
			periph_clk <= {`CC_NPER{main_clk}} & periph_run; // [RL20]
			periph_div_clk <= div_lvl[2:1];
		end
	end

	// RTC clocks from the 32 kHz oscillator
	logic rtc_q;
	logic [14:0] rtc_cnt;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rtc_q <= 1'b0;
			rtc_cnt <= 15'h0000;
			rtc_clk_1khz <= 1'b0;
			rtc_clk_1hz <= 1'b0;
		end else begin
			rtc_q <= rtc_f;
			if (rtc_f && !rtc_q)
				rtc_cnt <= rtc_cnt + 15'h0001;
			rtc_clk_1khz <= rtc_cnt[`CC_RTC_1K_BIT]; // [RL16]
			rtc_clk_1hz <= rtc_cnt[`CC_RTC_1HZ_BIT]; // [RL16]
		end
	end

	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_main_write;
		xfer && pwrite && hit_main;
	endsequence
	sequence s_sleep_write;
		xfer && pwrite && hit_slp && pwdata[0] && !wake_irq;
	endsequence

	AST_RESET_IRC: // [RL1]
	assert property ($past(!presetn) |-> main_sel == CC_SRC_IRC &&
		main_cur == CC_SRC_IRC)
	else $error("main clock not on rc oscillator after reset");

	AST_RESET_PLL_OFF: // [RL6]
	assert property ($past(!presetn) |-> pll_cfg[0].bypass &&
		!pll_cfg[0].en && pll_cfg[1].bypass && !pll_cfg[1].en)
	else $error("pll not off and bypassed after reset");

	AST_MAIN_SELECT: // [RL13]
	assert property (s_main_write |=> main_sel == $past(pwdata[2:0]))
	else $error("main source write lost");

	AST_SLEEP_ENTRY: // [RL19]
	assert property (s_sleep_write |=> core_sleeping)
	else $error("sleep write did not stop core");

	AST_CORE_STOPPED: // [RL19]
	assert property (core_sleeping && !div_lvl[0] |=> !core_clk ##1 !core_clk)
	else $error("core clock runs while stopped");

	AST_WAKE: // [RL20]
	assert property (core_sleeping && wake_irq |=> !core_sleeping ##1
		($past(div_lvl[0]) || core_run))
	else $error("interrupt did not wake core");

	AST_GATE_OFF: // [RL17]
	assert property (!gate[`CC_NPER-1] && !main_clk |=>
		##1 !periph_clk[`CC_NPER-1])
	else $error("gated peripheral clock toggled");

	AST_APB_ANSWER:
	assert property (acc && !pready |=> pready ##1 !pready)
	else $error("apb answer not one wait state");
endmodule : cc_clock_ctrl

/* verilog/cc_defs.svh */
// Constants and register map of the clock source, PLL and sleep control
// Summary of operation
// [RL1] Reset selects internal RC oscillator as source
// [RL2] PLL multiplier accepts integers 1 to 32
// [RL3] Post divider 2,4,8,16 gives even duty; code toggles whenever credit reaches the ratio, so duty is uneven
// [RL4] Software feeds PLL 10 to 25 MHz
// [RL5] Software keeps oscillator 156-320, output below 100
// [RL6] Reset leaves both PLLs off and bypassed
// [RL7] Software enables, waits lock, then selects PLL
// [RL8] Lock withheld until 100 us settling elapsed
// [RL9] Second identical PLL makes USB clock
// [RL10] Clock output pin picks one of four
// [RL11] Software waits 500 us for system oscillator
// [RL12] After wake software re-enables and waits stable
// [RL13] System oscillator feeds CPU directly or via PLL
// [RL14] Watchdog oscillator drives CPU, watchdog, output pin
// [RL15] Watchdog clock picks RC or watchdog oscillator
// [RL16] RTC oscillator gives 1 Hz, 1 kHz, 32 kHz
// [RL17] Per-peripheral register bit gates its clock
// [RL18] CPU divider plus separate peripheral dividers
// [RL19] Sleep stops core clock, re-enable resumes
// [RL20] Sleep lasts until reset or interrupt
// [RL21] Source muxes never emit shortened pulses
`ifndef CC_DEFS_SVH
`define CC_DEFS_SVH

// Register byte offsets
`define CC_OFF_MAINSEL 12'h000
`define CC_OFF_SYSPLL 12'h004
`define CC_OFF_USBPLL 12'h008
`define CC_OFF_STATUS 12'h00C
`define CC_OFF_CLOCK_OUTPUT_PIN 12'h010
`define CC_OFF_WDTSEL 12'h014
`define CC_OFF_CPUDIV 12'h018
`define CC_OFF_GATE 12'h01C
`define CC_OFF_PDIV0 12'h020
`define CC_OFF_PDIV1 12'h024
`define CC_OFF_SLEEP 12'h028

// Reset values
`define CC_RST_PLL 11'h200
`define CC_RST_CPUDIV 8'h01
`define CC_RST_GATE 8'h0F
`define CC_RST_PDIV 8'h00

// Field widths
`define CC_PLL_W 11
`define CC_DIV_W 8
`define CC_NPER 8

// Timing
`define CC_CLK_MHZ 125
`define CC_PLL_SETTLE_US 100

// RTC divider taps on a 32768 Hz edge count
`define CC_RTC_1K_BIT 4
`define CC_RTC_1HZ_BIT 14

`endif

/* verilog/cc_pkg.sv */
// Types shared by the clock control design
package cc_pkg;
	typedef enum logic [2:0] {
		CC_SRC_IRC = 3'b000,
		CC_SRC_SYSOSC = 3'b001,
		CC_SRC_WDO = 3'b010,
		CC_SRC_PLL = 3'b011,
		CC_SRC_RTC = 3'b100
	} cc_main_src_e;
	typedef enum logic {
		CC_MUX_RUN = 1'b0,
		CC_MUX_DROP = 1'b1
	} cc_mux_st_e;
	typedef struct packed {
		logic src;
		logic bypass;
		logic en;
		logic spare;
		logic [1:0] psel;
		logic [4:0] msel;
	} cc_pll_cfg_s;
	typedef struct packed {
		logic [2:0] main_src;
		logic sleeping;
		logic [1:0] lock;
	} cc_status_s;
endpackage : cc_pkg

/* verilog/cc_glitchless_mux.sv */
// Clock source selector that switches without runt pulses
`timescale 1ns/1ps
module cc_glitchless_mux
	import cc_pkg::*;
#(
	parameter int N = 8,
	parameter int W = 3
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Sources and selection
	input wire logic [N-1:0] src,
	input wire logic [W-1:0] sel,
	// Selected clock level
	output logic out,
	output logic [W-1:0] cur
);
	cc_mux_st_e st;
	wire cur_low = !src[cur];
	wire new_low = !src[sel];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= CC_MUX_RUN;
			cur <= '0;
			out <= 1'b0;
		end else begin
			case (st)
			CC_MUX_RUN: begin
				out <= src[cur];
				if (sel != cur && cur_low) begin // [RL21]
					st <= CC_MUX_DROP;
					out <= 1'b0;
				end
			end
			CC_MUX_DROP: begin
				out <= 1'b0;
				if (new_low) begin // [RL21]
					cur <= sel;
					st <= CC_MUX_RUN;
				end
			end
			default: st <= CC_MUX_RUN;
			endcase
		end
	end

	AST_MUX_HOLD_LOW: // [RL21]
	assert property (@(posedge pclk) disable iff (!presetn)
		out |-> $past(st == CC_MUX_RUN && src[cur]))
	else $error("mux output high while switching");
endmodule : cc_glitchless_mux

/* dv/cc_osc_model.sv */
// Oscillator sources and interrupting peripheral around the clock block
`timescale 1ns/1ps
module cc_osc_model #(
	parameter int HR = 4,
	parameter int HS = 5,
	parameter int HW = 7,
	parameter int HT = 6,
	parameter int START = 100
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Oscillator levels
	output logic rc,
	output logic sys,
	output logic wdo,
	output logic rtc,
	// Peripheral interrupt
	input wire logic wake_req,
	output logic wake_irq
);
	int c = 0;
	always @(posedge pclk) begin
		c <= c + 1;
		if (!presetn)
			wake_irq <= 1'b0;
		else
			wake_irq <= wake_req;
	end
	assign rc = ((c / HR) % 2) == 1;
	// System oscillator silent until its start-up time is over
	assign sys = (c >= START) && (((c / HS) % 2) == 1);
	assign wdo = ((c / HW) % 2) == 1;
	assign rtc = ((c / HT) % 2) == 1;
endmodule : cc_osc_model

/* dv/testbench.sv */
// Self-checking bench for the clock control block
`timescale 1ns/1ps
`include "cc_defs.svh"
module testbench;
	import cc_pkg::*;
	localparam int LK = 20;
	localparam int HR = 4;
	localparam int HS = 5;
	localparam int HW = 7;
	localparam int HT = 6;
	localparam logic [31:0] RV [9] = '{32'h0, `CC_RST_PLL, `CC_RST_PLL,
		32'h0, 32'h0, 32'h0, `CC_RST_CPUDIV, `CC_RST_GATE, `CC_RST_PDIV};
	localparam int MHP [5] = '{HR, HS, HW, 0, HT};
	localparam int PHP [4] = '{HR, HS, HW, HT};
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic wake_req = 1'b0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, err, rc, sys, wdo, rtc, wake_irq;
	logic main_clk, core_clk, usb_clk, wdt_clk, pin, r1hz, r1k, slp;
	logic [7:0] pclks, g;
	logic [1:0] pdclk;
	logic [4:0] m;
	integer seed = 32'hc00bfa27;
	int bad_count = 0;
	int checked = 0;
	int cycles = 0;
	int n;
	wire [15:0] mon = {pdclk, pclks, r1k, pin, wdt_clk, core_clk, usb_clk,
		main_clk};
	always #4 pclk = ~pclk;
	cc_clock_ctrl #(.LOCK_CYCLES(LK)) i_dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.internal_rc_oscillator(rc), .sys_oscillator(sys),
		.watchdog_oscillator(wdo), .rtc_osc_32k(rtc), .wake_irq(wake_irq),
		.main_clk(main_clk), .core_clk(core_clk), .usb_clk(usb_clk),
		.watchdog_timer_clock(wdt_clk), .clock_output_pin(pin),
		.rtc_clk_1hz(r1hz), .rtc_clk_1khz(r1k), .periph_clk(pclks),
		.periph_div_clk(pdclk), .core_sleeping(slp));
	cc_osc_model #(.HR(HR), .HS(HS), .HW(HW), .HT(HT)) i_osc (.pclk(pclk),
		.presetn(presetn), .rc(rc), .sys(sys), .wdo(wdo), .rtc(rtc),
		.wake_req(wake_req), .wake_irq(wake_irq));
	task automatic chk(input string nm, input logic [31:0] s, e);
		checked++;
		if (s !== e) begin
			bad_count++;
			$display("mismatch %s exp %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic apb(input logic w, input int a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a[11:0];
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (k == 20) bad_count++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic echk(input string nm, input int i, hp, dv, win);
		int cnt;
		int e;
		logic pv;
		repeat (40) @(posedge pclk);
		cnt = 0;
		pv = mon[i];
		repeat (win) begin
			@(posedge pclk);
			if (mon[i] && !pv) cnt++;
			pv = mon[i];
		end
		e = (hp == 0) ? 0 : win / (2 * hp * dv);
		chk(nm, 32'(cnt >= e - 1 && cnt <= e + 1 && (e > 0 || cnt == 0)), 1);
	endtask : echk
	task automatic summarize();
		$display("counts checked %0d bad %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : summarize
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 40000) begin
			bad_count++;
			summarize();
		end
	end
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		for (n = 0; n < 9; n++) begin
			apb(0, n * 4, 0);
			chk("reset value", rd, RV[n]);
		end
		apb(1, 12'h02C, 32'h5);
		chk("unmapped err", 32'(err), 1);
		apb(0, 12'h02C, 0);
		chk("unmapped data", rd, 0);
		$display("test reset and map done");
		// Sys osc start-up wait before it feeds the PLL or main clock
		repeat (120) @(posedge pclk);
		for (n = 0; n < 4; n++) begin
			m = 5'($random(seed));
			apb(1, `CC_OFF_SYSPLL, {21'h0, n[0], 3'b010, n[1:0], m});
			apb(0, `CC_OFF_STATUS, 0);
			chk("early lock", 32'(rd[0]), 0);
			repeat (LK) @(posedge pclk);
			apb(0, `CC_OFF_STATUS, 0);
			chk("lock", 32'(rd[0]), 1);
		end
		// M of 5 and ratio 2 on the system oscillator: half period 2
		apb(1, `CC_OFF_SYSPLL, {21'h0, 1'b1, 3'b010, 2'b00, 5'd4});
		repeat (LK + 2) @(posedge pclk);
		apb(1, `CC_OFF_MAINSEL, 3);
		repeat (40) @(posedge pclk);
		apb(0, `CC_OFF_STATUS, 0);
		chk("pll main src", 32'(rd[5:3]), 3);
		echk("pll runs", 0, HS * 2 / 5, 1, 240);
		apb(1, `CC_OFF_USBPLL, {21'h0, 4'b0010, 2'b01, 5'h03});
		repeat (LK + 2) @(posedge pclk);
		apb(0, `CC_OFF_STATUS, 0);
		chk("usb lock", 32'(rd[1:0]), 3);
		echk("usb runs", 1, HR * 4 / 4, 1, 240);
		$display("test pll done");
		for (n = 0; n < 5; n++) begin
			if (MHP[n] != 0) begin
				apb(1, `CC_OFF_MAINSEL, n);
				echk("main clk", 0, MHP[n], 1, 240);
			end
		end
		for (n = 0; n < 4; n++) begin
			apb(1, `CC_OFF_CLOCK_OUTPUT_PIN, n);
			echk("clock_output_pin", 4, PHP[n], 1, 240);
		end
		for (n = 0; n < 2; n++) begin
			apb(1, `CC_OFF_WDTSEL, n);
			echk("wdt clk", 3, n ? HW : HR, 1, 240);
		end
		echk("rtc 1k", 5, HT, 32, 1600);
		chk("rtc 1hz", 32'(r1hz), 0);
		$display("test routing done");
		apb(1, `CC_OFF_MAINSEL, 0);
		apb(1, `CC_OFF_CPUDIV, 3);
		apb(1, `CC_OFF_PDIV0, 4);
		apb(1, `CC_OFF_PDIV1, 2);
		echk("core div", 2, HR, 3, 240);
		echk("periph div", 14, HR, 4, 240);
		echk("periph div1", 15, HR, 2, 240);
		apb(1, `CC_OFF_CPUDIV, 0);
		echk("core stop", 2, 0, 1, 240);
		g = 8'($random(seed));
		apb(1, `CC_OFF_GATE, g);
		for (n = 0; n < 8; n++) begin
			echk("gate", 6 + n, g[n] ? HR : 0, 1, 120);
		end
		$display("test divide and gate done");
		apb(1, `CC_OFF_GATE, 8'h01);
		apb(1, `CC_OFF_CPUDIV, 1);
		apb(1, `CC_OFF_SLEEP, 1);
		apb(0, `CC_OFF_SLEEP, 0);
		chk("sleep reg", 32'(rd[0]), 1);
		chk("sleeping", 32'(slp), 1);
		echk("core asleep", 2, 0, 1, 240);
		echk("periph awake", 6, HR, 1, 240);
		@(posedge pclk);
		wake_req <= 1'b1;
		repeat (3) @(posedge pclk);
		wake_req <= 1'b0;
		repeat (2) @(posedge pclk);
		chk("woken", 32'(slp), 0);
		echk("core resumed", 2, HR, 1, 240);
		$display("test sleep done");
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, `CC_OFF_MAINSEL, 0);
		chk("rc after reset", rd, 0);
		apb(0, `CC_OFF_SYSPLL, 0);
		chk("pll after reset", rd, RV[1]);
		$display("test second reset done");
		summarize();
	end
endmodule : testbench
